// ### inc/fpga_config_init_control_defines.vh
// Constants for the configuration and initialization controller.
// Assumes a 100 MHz system clock and an include path that reaches inc/.
// Operation
// (RL1) Reconfiguration takes about 100 ms, clears state.
// (RL2) Host saves its own state before restarting.
// (RL3) Ten start-up clocks of initialization precede user mode.
// (RL4) Oscillator in self-load, host clock otherwise; the code also uses the oscillator in the host-fed strobed byte scheme.
// (RL5) User start-up clock option, at most 6 MHz.
// (RL6) Auto-restart only in self-loading schemes.
// (RL7) Error holds status low until restart pulse.
// (RL8) Auto-restart: status low ten clocks, then release.
// (RL9) User pins tri-stated throughout configuration.
// (RL10) Release order of override and clear selectable.
// (RL11) Device drives config clock, 2 to 6 MHz.
// (RL12) Config clock in user mode only if enabled.
// (RL13) Hold load_complete low, release, then input.
// (RL14) Rising load_complete starts initialization.
// (RL15) Time-out flags error after ten clocks.
// (RL16) Time-out disabled: wait forever, no error.
// (RL17) Outside party may hold load_complete low.
// (RL18) Three straps decode six schemes, two reserved.
// (RL19) Serial_parallel_select low serial, high parallel.
// (RL20) Status low at power-up, released within 100 ms.
// (RL21) Any configuration error pulls status low.
// (RL22) Restart low holds reset, rise starts configuration.
// (RL23) Start-up counter restarts each new cycle.
`ifndef FPGA_CONFIG_INIT_CONTROL_DEFINES_VH
`define FPGA_CONFIG_INIT_CONTROL_DEFINES_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_NS 10
`define OSC_HALF_NS 130
`define OSC_HALF_CYC (`OSC_HALF_NS / `CLK_NS)
`define POR_MS 100
`define POR_CYC (`POR_MS * 1000000 / `CLK_NS)
`define STARTUP_TICKS 4'ha
`define RELEASE1_TICK 4'h5
`define AUTO_LOW_TICKS 4'ha
`define TIMEOUT_TICKS 4'ha
// ----------------------------------------
// Schemes
// ----------------------------------------
`define SCH_EPROM_SERIAL_SELF_LOAD 3'h0
`define SCH_HOST_FED_SERIAL 3'h2
`define SCH_SELF_LOAD_BYTE_UP 3'h4
`define SCH_HOST_FED_BYTE_SYNC 3'h5
`define SCH_SELF_LOAD_BYTE_DOWN 3'h6
`define SCH_HOST_FED_BYTE_STROBED 3'h7
// ----------------------------------------
// Registers
// ----------------------------------------
`define REG_CTRL 2'h0
`define REG_STAT 2'h1
`define CTRL_RESET 5'h00
`define CTRL_USER_CLK 0
`define CTRL_AUTO_RESTART 1
`define CTRL_CLEARS_FIRST 2
`define CTRL_CLK_OUT 3
`define CTRL_TIMEOUT_DIS 4
`endif

// ### core/fpga_config_init_control.v
// Configuration and initialization sequencer with an Avalon-MM option port.
// Assumes the data loader reports load_done and data_error on this clock
// and that all pins pass through the three-stage filter below.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "fpga_config_init_control_defines.vh"

// ----------------------------------------
// Pin filter
// ----------------------------------------
module pin_filter #(
  parameter W = 1
) (
  input wire clock,
  input wire rst_n,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  // A bit changes only once the second and third stages agree.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q <= (s3_q & ~(s2_q ^ s3_q)) | (q & (s2_q ^ s3_q));
    end
  end
endmodule // pin_filter

// ----------------------------------------
// Controller
// ----------------------------------------
module fpga_config_init_control #(
  parameter POR_CYCLES = `POR_CYC
) (
  input wire clock,
  input wire nrst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire config_restart_n,
  input wire serial_parallel_select,
  input wire scheme_select_1,
  input wire scheme_select_0,
  input wire user_startup_clock,
  input wire config_clock_in,
  output reg config_clock_out,
  output reg config_clock_oe,
  input wire load_complete_in,
  output wire load_complete_out,
  output reg load_complete_oe,
  input wire status_error_n_in,
  output wire status_error_n_out,
  output reg status_error_n_oe,
  input wire load_done,
  input wire data_error,
  output reg user_oe_override,
  output reg user_clear,
  output reg user_mode
);
  localparam [3:0] S_RESET = 4'h0;
  localparam [3:0] S_POR = 4'h1;
  localparam [3:0] S_LOAD = 4'h2;
  localparam [3:0] S_WAIT = 4'h3;
  localparam [3:0] S_INIT = 4'h4;
  localparam [3:0] S_USER = 4'h5;
  localparam [3:0] S_ERROR = 4'h6;
  localparam [3:0] S_AUTO = 4'h7;
  localparam [23:0] POR_LIM = POR_CYCLES[23:0];
  localparam integer OSC_LIM_I = `OSC_HALF_CYC - 1;
  localparam [3:0] OSC_LIM = OSC_LIM_I[3:0];

  reg rst1_q;
  reg rst_n_q;
  wire [7:0] pins;
  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [2:0] scheme_q;
  reg [2:0] scheme_d;
  reg [3:0] cnt_q;
  reg [3:0] cnt_d;
  reg [23:0] por_q;
  reg [3:0] div_q;
  reg osc_q;
  reg osc_prev_q;
  reg usr_prev_q;
  reg hck_prev_q;
  reg lc_prev_q;
  reg restart_prev_q;
  reg [4:0] ctrl_q;
  reg ack_q;
  reg tmo_q;
  reg tmo_d;
  reg oe_d;
  reg clr_d;
  wire restart_n = pins[0];
  wire lc = pins[1];
  wire usr_ck = pins[2];
  wire host_ck = pins[3];
  wire [2:0] strap = pins[6:4]; // see (RL19)
  wire stat_pin = pins[7];
  wire self_load = (scheme_q == `SCH_EPROM_SERIAL_SELF_LOAD) ||
                   (scheme_q == `SCH_SELF_LOAD_BYTE_UP) ||
                   (scheme_q == `SCH_SELF_LOAD_BYTE_DOWN);
  wire host_fed = (scheme_q == `SCH_HOST_FED_SERIAL) || (scheme_q == `SCH_HOST_FED_BYTE_SYNC);
  wire drives_clk = self_load || (scheme_q == `SCH_HOST_FED_BYTE_STROBED);
  wire tick;
  reg tick_sel;

  // ----------------------------------------
  // Reset release and pin filtering
  // ----------------------------------------
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst1_q <= 1'b1;
      rst_n_q <= rst1_q;
    end
  end

  pin_filter #(.W(8)) u_pins (
    .clock(clock),
    .rst_n(rst_n_q),
    .d({status_error_n_in, serial_parallel_select, scheme_select_1, scheme_select_0, config_clock_in,
        user_startup_clock, load_complete_in, config_restart_n}),
    .q(pins)
  );

  // ----------------------------------------
  // Start-up clock selection
  // ----------------------------------------
  // The internal oscillator runs at 100 MHz / 26, close to 3.85 MHz.
  always @* begin
    if (ctrl_q[`CTRL_USER_CLK]) begin
      tick_sel = usr_ck & ~usr_prev_q; // see (RL5)
    end else if (host_fed) begin
      tick_sel = host_ck & ~hck_prev_q; // see (RL4)
    end else begin
      tick_sel = osc_q & ~osc_prev_q; // see (RL4)
    end
  end
  assign tick = tick_sel;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    scheme_d = scheme_q;
    cnt_d = cnt_q;
    tmo_d = tmo_q;
    case (state_q)
      S_POR: begin
        if (por_q == POR_LIM) begin
          state_d = restart_n ? S_LOAD : S_RESET; // see (RL20)
          scheme_d = strap;
          cnt_d = 4'h0;
        end
      end
      S_RESET: begin
        if (restart_n && !restart_prev_q) begin
          scheme_d = strap; // see (RL18)
          cnt_d = 4'h0; // see (RL23)
          tmo_d = 1'b0;
          state_d = S_LOAD; // see (RL22)
        end
      end
      S_LOAD: begin
        if (scheme_q == 3'h1 || scheme_q == 3'h3) begin
          state_d = S_ERROR; // see (RL18)
        end else if (data_error) begin
          // A host-fed scheme cannot refetch data, so it stops.
          state_d = (ctrl_q[`CTRL_AUTO_RESTART] && self_load) ? S_AUTO : S_ERROR; // see (RL6)
          cnt_d = 4'h0;
        end else if (load_done) begin
          state_d = S_WAIT; // see (RL13)
          cnt_d = 4'h0;
        end
      end
      S_WAIT: begin
        if (lc && !lc_prev_q) begin
          state_d = S_INIT; // see (RL14)
          cnt_d = 4'h0; // see (RL23)
        end else if (tick && cnt_q != `TIMEOUT_TICKS) begin
          cnt_d = cnt_q + 4'h1;
        end else if (cnt_q == `TIMEOUT_TICKS && !ctrl_q[`CTRL_TIMEOUT_DIS]) begin
          state_d = S_ERROR; // see (RL15)
          tmo_d = 1'b1;
        end
        // With the time-out disabled the count parks and waiting goes on. see (RL16) (RL17)
      end
      S_INIT: begin
        if (tick) begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q + 4'h1 == `STARTUP_TICKS) begin
            state_d = S_USER; // see (RL3)
          end
        end
      end
      S_AUTO: begin
        if (tick) begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q + 4'h1 == `AUTO_LOW_TICKS) begin
            state_d = S_LOAD; // see (RL8)
            cnt_d = 4'h0; // see (RL23)
          end
        end
      end
      S_USER: begin
        state_d = S_USER;
      end
      S_ERROR: begin
        state_d = S_ERROR; // see (RL7)
      end
      default: begin
        state_d = S_RESET;
      end
    endcase
    if (!restart_n && state_q != S_POR) begin
      state_d = S_RESET; // see (RL22)
    end
  end

  // Release order during initialization; the first release comes mid-sequence.
  always @* begin
    oe_d = 1'b1;
    clr_d = 1'b1;
    if (state_d == S_USER) begin
      oe_d = 1'b0;
      clr_d = 1'b0;
    end else if (state_d == S_INIT && cnt_d >= `RELEASE1_TICK) begin
      oe_d = ctrl_q[`CTRL_CLEARS_FIRST]; // see (RL10)
      clr_d = ~ctrl_q[`CTRL_CLEARS_FIRST]; // see (RL10)
    end
  end

  always @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= S_POR;
      scheme_q <= 3'h0;
      cnt_q <= 4'h0;
      por_q <= 24'h000000;
      div_q <= 4'h0;
      osc_q <= 1'b0;
      osc_prev_q <= 1'b0;
      usr_prev_q <= 1'b0;
      hck_prev_q <= 1'b0;
      lc_prev_q <= 1'b0;
      restart_prev_q <= 1'b0;
      tmo_q <= 1'b0;
      user_oe_override <= 1'b1;
      user_clear <= 1'b1;
      user_mode <= 1'b0;
      status_error_n_oe <= 1'b1;
      load_complete_oe <= 1'b0;
      config_clock_oe <= 1'b0;
      config_clock_out <= 1'b0;
    end else begin
      state_q <= state_d;
      scheme_q <= scheme_d;
      cnt_q <= cnt_d;
      tmo_q <= tmo_d;
      if (state_q == S_POR && por_q != POR_LIM) begin
        por_q <= por_q + 24'h000001;
      end
      if (div_q == OSC_LIM) begin
        div_q <= 4'h0;
        osc_q <= ~osc_q; // see (RL11)
      end else begin
        div_q <= div_q + 4'h1;
      end
      osc_prev_q <= osc_q;
      usr_prev_q <= usr_ck;
      hck_prev_q <= host_ck;
      lc_prev_q <= lc;
      restart_prev_q <= restart_n;
      user_oe_override <= oe_d; // see (RL9)
      user_clear <= clr_d; // see (RL1)
      user_mode <= (state_d == S_USER);
      status_error_n_oe <= (state_d == S_POR) || (state_d == S_RESET) || (state_d == S_ERROR) ||
                           (state_d == S_AUTO); // see (RL21)
      load_complete_oe <= (state_d == S_LOAD) || (state_d == S_RESET) || (state_d == S_AUTO) ||
                          (state_d == S_ERROR); // see (RL13)
      config_clock_out <= osc_q;
      config_clock_oe <= drives_clk && (((state_d == S_LOAD) || (state_d == S_WAIT) ||
                         (state_d == S_INIT)) ||
                         ((state_d == S_USER) && ctrl_q[`CTRL_CLK_OUT])); // see (RL11) (RL12)
    end
  end

  assign status_error_n_out = 1'b0;
  assign load_complete_out = 1'b0;

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  // Every access waits exactly one cycle, so read data is a registered snapshot.
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

  always @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
      ctrl_q <= `CTRL_RESET;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      if (avs_write && ack_q && avs_address[3:2] == `REG_CTRL) begin
        ctrl_q <= avs_writedata[4:0];
      end
      if (avs_read && !ack_q) begin
        case (avs_address[3:2])
          `REG_CTRL: begin
            avs_readdata <= {27'h0000000, ctrl_q};
          end
          `REG_STAT: begin
            avs_readdata <= {20'h00000, stat_pin, lc, tmo_q, user_mode, 1'b0, scheme_q,
                             state_q};
          end
          default: begin
            avs_readdata <= 32'h00000000;
          end
        endcase
      end
    end
  end
endmodule // fpga_config_init_control

// ### tb/fpga_config_init_control_properties.sv
// Port checker for the configuration controller.
// Assumes the straps change only while restart is held low.
`timescale 1ns/1ns
module cfg_ctrl_checker (
  input wire clock,
  input wire nrst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire config_restart_n,
  input wire serial_parallel_select,
  input wire scheme_select_1,
  input wire scheme_select_0,
  input wire config_clock_oe,
  input wire load_complete_oe,
  input wire status_error_n_oe,
  input wire user_oe_override,
  input wire user_clear,
  input wire user_mode
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  wire [2:0] sch = {serial_parallel_select, scheme_select_1, scheme_select_0};
  sequence one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence in_reset;
    ##[1:8] (user_oe_override && user_clear && !user_mode && status_error_n_oe);
  endsequence
  bus_wait_a: assert property ($rose(avs_read || avs_write) |-> one_wait)
    else $error("wait state count wrong");
  unmapped_zero_a: assert property (avs_read && avs_address[3] && !avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  power_up_low_a: assert property ($rose(nrst) |-> status_error_n_oe [*8])
    else $error("status not held low at power-up");
  restart_resets_a: assert property ($fell(config_restart_n) |-> in_reset)
    else $error("restart did not reset");
  user_pins_a: assert property (user_mode |-> !user_oe_override && !user_clear)
    else $error("user pins held in user mode");
  done_released_a: assert property (user_mode |-> !load_complete_oe)
    else $error("load line pulled in user mode");
  release_order_a: assert property ($fell(user_oe_override) |-> !$fell(user_clear))
    else $error("override and clear released together");
  host_clock_a: assert property (config_clock_oe && config_restart_n && $past(config_restart_n, 8)
    |-> sch != 3'h2 && sch != 3'h5)
    else $error("device drives host clock");
endmodule // cfg_ctrl_checker
bind fpga_config_init_control cfg_ctrl_checker i_chk (.clock, .nrst, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .config_restart_n, .serial_parallel_select, .scheme_select_1,
  .scheme_select_0, .config_clock_oe, .load_complete_oe, .status_error_n_oe, .user_oe_override,
  .user_clear, .user_mode);

// ### tb/cfg_host_model.sv
// Far-side model: link clocks and the pulled-up open-drain lines.
// Assumes the bench starts and stops the host clock around frames.
`timescale 1ns/1ns
module cfg_host_model (
  input wire run_clk,
  input wire hold_low,
  input wire load_complete_oe,
  input wire status_error_n_oe,
  output reg config_clock_in,
  output reg user_startup_clock,
  output wire load_complete_in,
  output wire status_error_n_in
);
  // ----------------------------------------
  // Clocks and lines
  // ----------------------------------------
  initial config_clock_in = 1'b0;
  initial user_startup_clock = 1'b0;
  // Host clock of 125 ns, parked low outside frames.
  always begin
    #62 config_clock_in = run_clk & ~config_clock_in;
    #63 config_clock_in = run_clk & ~config_clock_in;
  end
  // User clock stays under 6 MHz with an even duty cycle.
  always #130 user_startup_clock = ~user_startup_clock;
  // Pull-ups win unless a party pulls low, so holding low delays start-up.
  assign load_complete_in = !(load_complete_oe || hold_low);
  assign status_error_n_in = !status_error_n_oe;
endmodule // cfg_host_model

// ### tb/testbench.sv
// Self-checking bench for the configuration controller.
// Assumes the host model resolves the open-drain lines.
`timescale 1ns/1ns
`include "fpga_config_init_control_defines.vh"
module testbench;
  localparam P = 2 * `OSC_HALF_CYC;
  reg clock = 1'b0;
  reg nrst = 1'b0;
  reg [3:0] avs_address = 4'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg config_restart_n = 1'b1;
  reg [2:0] sch = 3'h0;
  reg load_done = 1'b0;
  reg data_error = 1'b0;
  reg run_clk = 1'b0;
  reg hold_low = 1'b0;
  reg [31:0] q;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, config_clock_in, user_startup_clock, load_complete_in, load_complete_oe;
  wire status_error_n_in, status_error_n_oe, config_clock_oe, user_oe_override, user_clear, user_mode;
  wire config_clock_out, load_complete_out, status_error_n_out;
  integer miscompares = 0;
  integer n_checks = 0;
  integer c;
  integer k;
  integer t;
  always #5 clock = ~clock;
  fpga_config_init_control #(.POR_CYCLES(20)) i_dut (.clock(clock), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .config_restart_n(config_restart_n), .serial_parallel_select(sch[2]),
    .scheme_select_1(sch[1]), .scheme_select_0(sch[0]), .user_startup_clock(user_startup_clock),
    .config_clock_in(config_clock_in), .config_clock_out(config_clock_out), .config_clock_oe(config_clock_oe),
    .load_complete_in(load_complete_in), .load_complete_out(load_complete_out),
    .load_complete_oe(load_complete_oe), .status_error_n_in(status_error_n_in),
    .status_error_n_out(status_error_n_out), .status_error_n_oe(status_error_n_oe),
    .load_done(load_done), .data_error(data_error), .user_oe_override(user_oe_override),
    .user_clear(user_clear), .user_mode(user_mode));
  cfg_host_model i_host (.run_clk(run_clk), .hold_low(hold_low), .load_complete_oe(load_complete_oe),
    .status_error_n_oe(status_error_n_oe), .config_clock_in(config_clock_in),
    .user_startup_clock(user_startup_clock), .load_complete_in(load_complete_in),
    .status_error_n_in(status_error_n_in));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task results;
    begin
      if (miscompares == 0 && n_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        $display("BAD %0t got %h exp %h", $time, g, e);
        miscompares = miscompares + 1;
      end
    end
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    integer n;
    begin
      n = 0;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0 && n < 9) begin
        @(posedge clock);
        n = n + 1;
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      chk(n < 9, 1);
      if (n == 9) results;
    end
  endtask
  task until_state(input [3:0] s);
    integer n;
    begin
      n = 0;
      bus(1'b0, 4'h4, 32'h0);
      while (q[3:0] !== s && n < 400) begin
        bus(1'b0, 4'h4, 32'h0);
        n = n + 1;
      end
      chk(q[3:0], s);
      if (q[3:0] !== s) results;
    end
  endtask
  task cycles(input integer sel);
    begin
      c = 0;
      while (c < 2000 && !(sel == 0 ? user_mode === 1'b1 : sel == 1 ? status_error_n_oe === 1'b0
          : (user_oe_override & user_clear) === 1'b0)) begin
        @(posedge clock);
        c = c + 1;
      end
      chk(c < 2000, 1);
      if (c == 2000) results;
    end
  endtask
  // A restart holds the pin low for eight cycles, well past the input filter.
  // The control register is reset only by nrst, so a restart keeps the settings the bench wrote.
  task start(input [2:0] s);
    begin
      @(posedge clock);
      config_restart_n <= 1'b0;
      sch <= s;
      repeat (8) @(posedge clock);
      config_restart_n <= 1'b1;
    end
  endtask
  task pulse(input e);
    begin
      @(posedge clock);
      load_done <= !e;
      data_error <= e;
      @(posedge clock);
      load_done <= 1'b0;
      data_error <= 1'b0;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task s_boot;
    begin
      repeat (6) @(posedge clock);
      chk({status_error_n_oe, load_complete_out, status_error_n_out}, 3'h4);
      bus(1'b0, 4'hc, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, 4'h0, 32'h0);
      chk(q, `CTRL_RESET);
      until_state(4'h2);
      chk({status_error_n_oe, load_complete_oe, user_oe_override, q[6:4]}, 6'h18);
      for (k = 0; k < 2; k = k + 1) begin
        bus(1'b1, 4'h0, k ? 32'hd : 32'h0);
        start(3'h0);
        until_state(4'h2);
        pulse(1'b0);
        cycles(2);
        t = c;
        chk({user_oe_override, user_clear}, k ? 2'h2 : 2'h1);
        cycles(0);
        chk(t + c > 9 * P && t + c < 11 * P + 12, 1);
        chk({config_clock_oe, load_complete_in, user_mode}, k ? 3'h7 : 3'h3);
      end
    end
  endtask
  // The device clock must sit in its 2 to 6 MHz band: 17 to 50 system cycles a period.
  task s_clock;
    integer e0;
    reg ck_prev;
    begin
      c = 0;
      t = 0;
      e0 = 0;
      ck_prev = 1'b1;
      while (t < 2 && c < 200) begin
        @(posedge clock);
        c = c + 1;
        if (config_clock_out === 1'b1 && ck_prev === 1'b0) begin
          t = t + 1;
          if (t == 1) e0 = c;
        end
        ck_prev = config_clock_out;
      end
      chk(t == 2 && c - e0 > 16 && c - e0 < 51, 1);
      if (t < 2) results;
    end
  endtask
  task s_schemes;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        start(k[2:0]);
        until_state(k == 1 || k == 3 ? 4'h6 : 4'h2);
        if (k != 1 && k != 3) chk(q[6:4], k[2:0]);
        chk(status_error_n_oe, k == 1 || k == 3);
      end
    end
  endtask
  task s_error;
    begin
      bus(1'b1, 4'h0, 32'h2);
      start(3'h2);
      until_state(4'h2);
      pulse(1'b1);
      repeat (300) @(posedge clock);
      bus(1'b0, 4'h4, 32'h0);
      chk({q[3:0], status_error_n_oe}, 5'hd);
      start(3'h4);
      until_state(4'h2);
      chk(status_error_n_oe, 0);
      pulse(1'b1);
      repeat (2) @(posedge clock);
      cycles(1);
      chk(c + 2 > 9 * P && c + 2 < 11 * P + 12, 1);
      until_state(4'h2);
      pulse(1'b0);
      cycles(0);
      chk(c > 9 * P && c < 11 * P + 12, 1);
    end
  endtask
  task s_timeout;
    begin
      bus(1'b1, 4'h0, 32'h0);
      run_clk <= 1'b1;
      hold_low <= 1'b1;
      start(3'h2);
      until_state(4'h2);
      pulse(1'b0);
      until_state(4'h6);
      chk({q[9], status_error_n_oe}, 2'h3);
      bus(1'b1, 4'h0, 32'h10);
      start(3'h5);
      until_state(4'h2);
      pulse(1'b0);
      repeat (400) @(posedge clock);
      bus(1'b0, 4'h4, 32'h0);
      chk({q[9], q[3:0], status_error_n_oe}, 6'h06);
      hold_low <= 1'b0;
      until_state(4'h5);
      run_clk <= 1'b0;
    end
  endtask
  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    s_boot;
    s_clock;
    s_schemes;
    s_error;
    s_timeout;
    results;
  end
endmodule // testbench
